// ---- hdl/e3_ovh_pkg.sv ----
// constants for the e3 transmit overhead insertion port
// assumes a 250 MHz core clock and one e3 bit strobe from the framer core
package e3_ovh_pkg;

  localparam int          OVH_BITS      = 12;
  localparam int          OVH_IDX_W     = 4;
  localparam logic [3:0]  IDX_FAS_MSB   = 4'h0;
  localparam logic [3:0]  IDX_ALARM     = 4'hA;
  localparam logic [3:0]  IDX_NATIONAL  = 4'hB;
  localparam logic [3:0]  IDX_LAST      = 4'hB;
  // insertable positions: fas 9..0, alarm, national
  localparam logic [11:0] OVH_ACCEPT    = 12'hFFF;
  localparam logic [11:0] OVH_RESET     = 12'h000;
  // overhead clock high and low phase lengths in core clocks, minus one
  localparam logic [1:0]  CLK_HALF      = 2'h1;

  typedef enum logic [2:0] {
    ST_IDLE = 3'b001,
    ST_HIGH = 3'b010,
    ST_LOW  = 3'b100
  } ovh_clk_state_t;

endpackage : e3_ovh_pkg

// ---- hdl/e3_ovh_sync.sv ----
// two-stage synchroniser for terminal-driven pins
// assumes inputs are asynchronous to CLK
`timescale 1ns/1ps
`default_nettype none
module e3_ovh_sync (
  // clock and reset
  input  wire logic CLK,
  input  wire logic RESETN,
  // data
  input  wire logic din,
  output var  logic dout
);

  logic meta;

  always_ff @(posedge CLK or negedge RESETN) begin
    if (!RESETN) begin
      meta <= 1'b0;
      dout <= 1'b0;
    end else begin
      meta <= din;
      dout <= meta;
    end
  end

endmodule : e3_ovh_sync
`default_nettype wire

// ---- hdl/e3_tx_overhead_insert_port.sv ----
// e3 transmit overhead insertion port, overhead clock method
// assumes framer core gives a bit strobe, overhead flag, index and last-bit flag
//
// Overview of operation
// [R01] with insert enable high, data is captured at overhead clock falling edge
// [R02] with insert enable low, the data pin is ignored
// [R03] captured values go into their position in the next outbound frame
// [R04] overhead clock rises one bit period before each overhead bit
// [R05] overhead clock pulses for every overhead bit, insertable or not
// [R06] frame marker is high while the last frame bit is processed
// [R07] terminal samples the frame marker on overhead clock rising edges
// [R08] terminal counts rising edges since marker seen high
// [R09] counts 0..9 map to alignment bits 9 down to 0, all accepted
// [R10] count 10 is alarm bit, count 11 national bit, both accepted
// [R11] terminal raises insert enable and data together at wanted count
// [R12] terminal holds enable and data until next overhead clock rise
// [R13] insertion on a non-acceptable position is discarded
// [R14] positions with no accepted insertion send internal values
`timescale 1ns/1ps
`default_nettype none
module e3_tx_overhead_insert_port
  import e3_ovh_pkg::*;
(
  // clock and reset
  input  wire logic        CLK,
  input  wire logic        RESETN,
  // framer core side
  input  wire logic        BIT_STROBE,
  input  wire logic        NEXT_IS_OVH,
  input  wire logic [3:0]  NEXT_OVH_IDX,
  input  wire logic        LAST_BIT,
  input  wire logic        OVH_NOW,
  input  wire logic [3:0]  OVH_NOW_IDX,
  input  wire logic        INTERNAL_BIT,
  // terminal side
  input  wire logic        OVERHEAD_BIT_IN,
  input  wire logic        OVERHEAD_INSERT_ENABLE,
  output var  logic        OVERHEAD_CLOCK_OUT,
  output var  logic        OVERHEAD_FRAME_MARKER,
  // outbound overhead bit to framer core
  output var  logic        OVH_BIT_OUT
);

  ovh_clk_state_t        state;
  logic [1:0]            phase;
  logic                  ins_s;
  logic                  dat_s;
  logic [3:0]            clk_idx;
  logic [OVH_BITS-1:0]   pend_val;
  logic [OVH_BITS-1:0]   pend_vld;
  logic [OVH_BITS-1:0]   cur_val;
  logic [OVH_BITS-1:0]   cur_vld;
  logic                  fall;

  // ****************************************************************
  // pin synchronisers
  // ****************************************************************
  e3_ovh_sync u_sync_ins (
    .CLK    (CLK),
    .RESETN (RESETN),
    .din    (OVERHEAD_INSERT_ENABLE),
    .dout   (ins_s)
  );

  e3_ovh_sync u_sync_dat (
    .CLK    (CLK),
    .RESETN (RESETN),
    .din    (OVERHEAD_BIT_IN),
    .dout   (dat_s)
  );

  // ****************************************************************
  // overhead clock generator
  // ****************************************************************
  // a short high-low pulse is launched on the bit ahead of each overhead bit,
  // so the rise leads that bit by one bit period
  always_ff @(posedge CLK or negedge RESETN) begin
    if (!RESETN) begin
      state              <= ST_IDLE;
      phase              <= 2'h0;
      clk_idx            <= 4'h0;
      OVERHEAD_CLOCK_OUT <= 1'b0;
    end else begin
      case (state)
        ST_IDLE: begin
          if (BIT_STROBE && NEXT_IS_OVH) begin
            state              <= ST_HIGH;                     // R04 R05
            clk_idx            <= NEXT_OVH_IDX;
            phase              <= CLK_HALF;
            OVERHEAD_CLOCK_OUT <= 1'b1;
          end
        end
        ST_HIGH: begin
          if (phase == 2'h0) begin
            state              <= ST_LOW;
            phase              <= CLK_HALF;
            OVERHEAD_CLOCK_OUT <= 1'b0;
          end else begin
            phase <= phase - 2'h1;
          end
        end
        ST_LOW: begin
          if (phase == 2'h0) begin
            state <= ST_IDLE;
          end else begin
            phase <= phase - 2'h1;
          end
        end
        default: begin
          state              <= ST_IDLE;
          OVERHEAD_CLOCK_OUT <= 1'b0;
        end
      endcase
    end
  end

  // sample point sits in the low phase, giving the synchronisers time
  // to settle after the terminal's change at the rising edge
  assign fall = (state == ST_LOW) && (phase == 2'h0);

  // ****************************************************************
  // frame marker
  // ****************************************************************
  always_ff @(posedge CLK or negedge RESETN) begin
    if (!RESETN) begin
      OVERHEAD_FRAME_MARKER <= 1'b0;
    end else if (BIT_STROBE) begin
      OVERHEAD_FRAME_MARKER <= LAST_BIT;                       // R06
    end
  end

  // ****************************************************************
  // capture into pending frame buffer
  // ****************************************************************
  generate
    for (genvar i = 0; i < OVH_BITS; i++) begin : g_cap
      always_ff @(posedge CLK or negedge RESETN) begin
        if (!RESETN) begin
          pend_val[i] <= OVH_RESET[i];
          pend_vld[i] <= OVH_RESET[i];
          cur_val[i]  <= OVH_RESET[i];
          cur_vld[i]  <= OVH_RESET[i];
        end else begin
          // at frame end the pending set becomes the live set
          if (BIT_STROBE && LAST_BIT) begin
            cur_val[i]  <= pend_val[i];                        // R03
            cur_vld[i]  <= pend_vld[i];
            pend_vld[i] <= 1'b0;
          end
          // R09 R10: index order fas9..fas0, alarm, national
          if (fall && ins_s && clk_idx == 4'(i) && OVH_ACCEPT[i]) begin
            pend_val[i] <= dat_s;                              // R01 R13
            pend_vld[i] <= 1'b1;
          end                                                  // R02
        end
      end
    end
  endgenerate

  // ****************************************************************
  // outbound overhead bit
  // ****************************************************************
  always_ff @(posedge CLK or negedge RESETN) begin
    if (!RESETN) begin
      OVH_BIT_OUT <= 1'b0;
    end else if (OVH_NOW && OVH_NOW_IDX <= IDX_LAST) begin
      OVH_BIT_OUT <= cur_vld[OVH_NOW_IDX] ? cur_val[OVH_NOW_IDX]
                                          : INTERNAL_BIT;     // R14
    end else begin
      OVH_BIT_OUT <= INTERNAL_BIT;
    end
  end

endmodule : e3_tx_overhead_insert_port
`default_nettype wire

// ---- tb/e3_ovh_sva.sv ----
// checker for the overhead insertion port
// assumes it is bound to the port top; one core clock domain
`timescale 1ns/1ps
`default_nettype none
module e3_ovh_sva (
  // clock, reset and core side
  input wire logic CLK,
  input wire logic RESETN,
  input wire logic BIT_STROBE,
  input wire logic NEXT_IS_OVH,
  input wire logic LAST_BIT,
  input wire logic OVH_NOW,
  input wire logic INTERNAL_BIT,
  // port outputs
  input wire logic OVERHEAD_CLOCK_OUT,
  input wire logic OVERHEAD_FRAME_MARKER,
  input wire logic OVH_BIT_OUT
);
  default clocking @(posedge CLK); endclocking
  default disable iff (!RESETN);
  a_clk_rise_next: assert property (
    BIT_STROBE && NEXT_IS_OVH && !OVERHEAD_CLOCK_OUT |=> OVERHEAD_CLOCK_OUT) else $error("rise");
  a_clk_two_high: assert property ($rose(OVERHEAD_CLOCK_OUT) |=>
    OVERHEAD_CLOCK_OUT ##1 !OVERHEAD_CLOCK_OUT) else $error("clock width");
  a_clk_has_cause: assert property ($rose(OVERHEAD_CLOCK_OUT) |->
    $past(BIT_STROBE) && $past(NEXT_IS_OVH)) else $error("clock cause");
  a_clk_quiet: assert property (BIT_STROBE && !NEXT_IS_OVH |=>
    !OVERHEAD_CLOCK_OUT [*4]) else $error("clock on payload");
  a_mark_last: assert property (BIT_STROBE && LAST_BIT |=>
    OVERHEAD_FRAME_MARKER) else $error("marker set");
  a_mark_clear: assert property (BIT_STROBE && !LAST_BIT |=>
    !OVERHEAD_FRAME_MARKER) else $error("marker clear");
  a_mark_steady: assert property (!BIT_STROBE |=>
    $stable(OVERHEAD_FRAME_MARKER)) else $error("marker moved");
  a_payload_pass: assert property (!OVH_NOW |=>
    OVH_BIT_OUT == $past(INTERNAL_BIT)) else $error("internal bit");
endmodule : e3_ovh_sva
bind e3_tx_overhead_insert_port e3_ovh_sva i_e3_ovh_sva (.*);
`default_nettype wire

// ---- tb/e3_ovh_term.sv ----
// terminal model feeding overhead bits
// assumes marker and overhead clock come from the port
`timescale 1ns/1ps
`default_nettype none
module e3_ovh_term (
  input  wire logic        ovh_clk,
  input  wire logic        marker,
  input  wire logic [11:0] want,
  input  wire logic [11:0] val,
  output var  logic        ins_en,
  output var  logic        ins_bit
);
  logic [3:0] cnt = 4'hF;
  initial {ins_en, ins_bit} = 2'h0;
  // act just after the rise so the marker has settled
  always @(posedge ovh_clk) begin
    #1;
    cnt = marker ? 4'h0 : cnt + 4'h1;
    ins_en = cnt < 4'hC && want[cnt];
    ins_bit = ins_en ? val[cnt] : ~ins_bit;
  end
endmodule : e3_ovh_term
`default_nettype wire

// ---- tb/testbench.sv ----
// bench: framer core model, terminal model, self checks
// assumes a 16-clock e3 bit period, 12 overhead bits then 4 payload
`timescale 1ns/1ps
`default_nettype none
module testbench;
  logic        CLK = 1'h0, RESETN = 1'h0, BIT_STROBE = 1'h0, run = 1'h0, prev = 1'h0;
  logic [3:0]  ph = 4'hF, bn = 4'hE, rises = 4'h0;
  logic [7:0]  rnd = 8'h28;
  logic [11:0] w1 = 12'h0, w2 = 12'h0, v1 = 12'h0, v2 = 12'h0;
  wire logic   clk_o, mark, obit, ins_en, ins_bit;
  int          err_count = 0, checked = 0, fr = 0;
  e3_tx_overhead_insert_port i_e3_tx_overhead_insert_port (.CLK, .RESETN, .BIT_STROBE,
    .NEXT_IS_OVH(bn == 4'hF || bn < 4'hB), .NEXT_OVH_IDX(bn + 4'h1), .LAST_BIT(bn == 4'hF),
    .OVH_NOW(bn < 4'hC), .OVH_NOW_IDX(bn), .INTERNAL_BIT(rnd[0]), .OVERHEAD_BIT_IN(ins_bit),
    .OVERHEAD_INSERT_ENABLE(ins_en), .OVERHEAD_CLOCK_OUT(clk_o),
    .OVERHEAD_FRAME_MARKER(mark), .OVH_BIT_OUT(obit));
  e3_ovh_term i_e3_ovh_term (.ovh_clk(clk_o), .marker(mark), .want(w1), .val(v1),
    .ins_en(ins_en), .ins_bit(ins_bit));
  function automatic logic [7:0] lfsr(input logic [7:0] s);
    return {s[6:0], s[7] ^ s[5] ^ s[4] ^ s[3]};
  endfunction : lfsr
  task automatic chk(input string n, input logic [3:0] e, input logic [3:0] g);
    checked++;
    if (e !== g) begin
      err_count++;
      $display("Error %s expected %0h seen %0h", n, e, g);
    end
  endtask : chk
  task automatic summarize;
    $display("comparisons %0d mismatches %0d", checked, err_count);
    if (err_count == 0 && checked > 0) $display("STATUS OK");
    else $display("STATUS NOT OK");
    $finish;
  endtask : summarize
  initial forever #2 CLK = ~CLK;
  // framer core: strobe at phase 0, checks mid-bit where outputs have settled
  always @(negedge CLK) if (run) begin
    ph = ph + 4'h1;
    BIT_STROBE <= ph == 4'h0;
    if (ph == 4'h0) begin
      bn = bn + 4'h1;
      rnd = lfsr(rnd);
      if (bn == 4'h0) begin
        fr++;
        $display("frame %0d done", fr);
      end
      if (bn == 4'hF) begin
        if (fr > 0) chk("clock pulses", 4'hC, rises);
        rises = 4'h0;
        w2 = w1;
        v2 = v1;
        // first a lone alarm bit, then all twelve forced low, then random
        w1 = fr == 0 ? 12'h400 : fr == 1 ? 12'hFFF : {rnd[3:0], rnd};
        v1 = fr == 0 ? 12'hFFF : fr == 1 ? 12'h000 : {rnd[5:0], rnd[7:2]};
      end
    end
    if (ph == 4'h8) begin
      chk("frame marker", 4'(bn == 4'hF), 4'(mark));
      chk("overhead bit", 4'(bn < 4'hC && w2[bn] ? v2[bn] : rnd[0]), 4'(obit));
    end
    if (clk_o && !prev) rises++;
    prev = clk_o;
  end
  initial begin
    repeat (12) @(posedge CLK);
    @(negedge CLK) RESETN = 1'h1;
    run <= 1'h1;
    wait (fr == 14);
    summarize();
  end
  initial begin
    #40000 err_count++;
    summarize();
  end
endmodule : testbench
`default_nettype wire
